// file: rtl/mfs_status_bank.sv
// Purpose: motion feature status bank behind an AHB-Lite slave port
// Assumes: event inputs are synchronous one-cycle pulses, results are levels
// Notes: zero wait states, always OKAY, unmapped reads return zero
`timescale 1ns/100ps
`include "mfs_cfg.svh"

// Summary of operation
// - reading the feature flag register clears the flags it returned
// - buffer and ready flags clear when the read data phase completes
// - significant motion bit 0, stillness bit 5, movement bit 6, bit 7 zero
// - bit 1 follows step watermark or single step, chosen by step mode
// - activity change bit 2, wear-to-wake bit 3, wrist gesture bit 4
// - second flags reset zero; buffer full bit 0, watermark bit 1, error 2
// - auxiliary ready bit 5, angular rate ready bit 6, acceleration bit 7
// - step count low byte at lower index, high byte at next index
// - gesture code in bits 2:0, unknown after reset
// - activity code in bits 4:3, unknown code 3 after reset
module mfs_status_bank (
    input wire logic mclk_in,
    input wire logic rstn_in,
    // register bus
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // feature events
    input wire logic sig_motion_in,
    input wire logic step_wm_in,
    input wire logic step_det_in,
    input wire logic activity_chg_in,
    input wire logic wear_wake_in,
    input wire logic gesture_det_in,
    input wire logic still_det_in,
    input wire logic motion_det_in,
    // buffer, error and ready events
    input wire logic buf_full_in,
    input wire logic buf_wm_in,
    input wire logic error_in,
    input wire logic aux_rdy_in,
    input wire logic gyr_rdy_in,
    input wire logic acc_rdy_in,
    // results
    input wire logic [15:0] step_count_in,
    input wire logic result_upd_in,
    input wire mfs_pkg::mfs_gest_e gesture_in,
    input wire mfs_pkg::mfs_act_e activity_in,
    // interrupt
    output logic irq_out
);
    import mfs_pkg::*;

    logic take;
    logic addr_ok;
    logic [7:0] take_idx;
    mfs_phase_e phase;
    mfs_phase_e next_phase;
    logic [7:0] dp_idx;
    logic [31:0] next_rdata;

    logic [7:0] feat_set;
    logic [7:0] feat_clr;
    logic [7:0] feat_flags;
    logic [7:0] irq_set;
    logic [7:0] irq_clr;
    logic [7:0] irq_flags;
    logic [7:0] irq_snap;

    logic [7:0] feat_mask;
    logic [7:0] irq_mask;
    logic step_sel_det;
    logic [15:0] step_total;
    mfs_gest_e gest_code;
    mfs_act_e act_code;
    logic next_irq;

    // address phase decode
    assign take = hsel_in & htrans_in[1] & hready_in;
    assign take_idx = haddr_in[9:2];
    assign addr_ok = (haddr_in[31:10] == 22'h000000) && (haddr_in[1:0] == 2'h0);

    // read strobes at the address phase edge
    logic rd_take;
    logic rd_feat;
    logic rd_irq;
    assign rd_take = take & ~hwrite_in;
    assign rd_feat = rd_take & addr_ok & (take_idx == `MFS_IDX_FEAT);
    assign rd_irq = rd_take & addr_ok & (take_idx == `MFS_IDX_IRQ);

    // strobes at the edge ending the data phase
    logic irq_dp_end;
    logic wr_feat_mask;
    logic wr_irq_mask;
    logic wr_step_cfg;
    assign irq_dp_end = (phase == MFS_PH_RD) && (dp_idx == `MFS_IDX_IRQ);
    assign wr_feat_mask = (phase == MFS_PH_WR) && (dp_idx == `MFS_IDX_FEAT_MASK);
    assign wr_irq_mask = (phase == MFS_PH_WR) && (dp_idx == `MFS_IDX_IRQ_MASK);
    assign wr_step_cfg = (phase == MFS_PH_WR) && (dp_idx == `MFS_IDX_STEP_CFG);

    // next bus phase from the address phase
    always_comb begin
        next_phase = MFS_PH_IDLE;
        if (take) begin
            if (hwrite_in) begin
                next_phase = MFS_PH_WR;
            end else begin
                next_phase = MFS_PH_RD;
            end
        end
    end

    // data phase tracker
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phase <= MFS_PH_IDLE;
            dp_idx <= 8'h00;
        end else begin
            phase <= next_phase;
            if (take) begin
                if (addr_ok) begin
                    dp_idx <= take_idx;
                end else begin
                    dp_idx <= 8'hFF;
                end
            end
        end
    end

    // bus answer, never stalls
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hreadyout_out <= 1'b1;
        end else begin
            hreadyout_out <= 1'b1;
        end
    end

    // response is always okay
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hresp_out <= 1'b0;
        end else begin
            hresp_out <= 1'b0;
        end
    end

    // read mux, sampled at the address phase edge
    always_comb begin
        next_rdata = 32'h00000000;
        if (addr_ok) begin
            case (take_idx)
                `MFS_IDX_FEAT: begin
                    next_rdata[7:0] = feat_flags;
                end
                `MFS_IDX_IRQ: begin
                    // bits clearing at this edge are not returned twice
                    next_rdata[7:0] = irq_flags & ~irq_clr;
                end
                `MFS_IDX_STEP_LO: begin
                    next_rdata[7:0] = step_total[7:0];
                end
                `MFS_IDX_STEP_HI: begin
                    next_rdata[7:0] = step_total[15:8];
                end
                `MFS_IDX_GEST_ACT: begin
                    next_rdata[`MFS_GEST_MSB:`MFS_GEST_LSB] = gest_code;
                    next_rdata[`MFS_ACT_MSB:`MFS_ACT_LSB] = act_code;
                end
                `MFS_IDX_FEAT_MASK: begin
                    next_rdata[7:0] = feat_mask;
                end
                `MFS_IDX_IRQ_MASK: begin
                    next_rdata[7:0] = irq_mask;
                end
                `MFS_IDX_STEP_CFG: begin
                    next_rdata[0] = step_sel_det;
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // read data register, holds until the next read
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hrdata_out <= 32'h00000000;
        end else if (rd_take) begin
            hrdata_out <= next_rdata;
        end
    end

    // feature mask, unimplemented bits stay zero
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            feat_mask <= `MFS_MASK_RESET;
        end else if (wr_feat_mask) begin
            feat_mask <= hwdata_in[7:0] & `MFS_FEAT_IMPL;
        end
    end

    // irq mask, unimplemented bits stay zero
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_mask <= `MFS_MASK_RESET;
        end else if (wr_irq_mask) begin
            irq_mask <= hwdata_in[7:0] & `MFS_IRQ_IMPL;
        end
    end

    // step function select, 1 picks the single-step detector
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            step_sel_det <= 1'b0;
        end else if (wr_step_cfg) begin
            step_sel_det <= hwdata_in[0];
        end
    end

    // feature event mapping
    always_comb begin
        feat_set = 8'h00;
        feat_set[`MFS_FEAT_SIG_MOTION] = sig_motion_in;
        feat_set[`MFS_FEAT_STEP] = step_sel_det ? step_det_in : step_wm_in;
        feat_set[`MFS_FEAT_ACTIVITY] = activity_chg_in;
        feat_set[`MFS_FEAT_WEAR_WAKE] = wear_wake_in;
        feat_set[`MFS_FEAT_GESTURE] = gesture_det_in;
        feat_set[`MFS_FEAT_STILL] = still_det_in;
        feat_set[`MFS_FEAT_MOTION] = motion_det_in;
    end

    // feature flags clear as their value is taken for the read
    always_comb begin
        feat_clr = 8'h00;
        if (rd_feat) begin
            feat_clr = feat_flags;
        end
    end

    // sticky feature flags
    mfs_evt_flags #(
        .WIDTH(8),
        .IMPL(`MFS_FEAT_IMPL),
        .RESET(`MFS_FEAT_RESET)
    ) u_feat_flags (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .set_in(feat_set),
        .clr_in(feat_clr),
        .flags_out(feat_flags)
    );

    // buffer, error and ready event mapping
    always_comb begin
        irq_set = 8'h00;
        irq_set[`MFS_IRQ_BUF_FULL] = buf_full_in;
        irq_set[`MFS_IRQ_BUF_WM] = buf_wm_in;
        irq_set[`MFS_IRQ_ERROR] = error_in;
        irq_set[`MFS_IRQ_AUX_RDY] = aux_rdy_in;
        irq_set[`MFS_IRQ_GYR_RDY] = gyr_rdy_in;
        irq_set[`MFS_IRQ_ACC_RDY] = acc_rdy_in;
    end

    // snapshot of the returned value, cleared when the data phase ends
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_snap <= 8'h00;
        end else if (rd_irq) begin
            irq_snap <= irq_flags & ~irq_clr;
        end else begin
            irq_snap <= 8'h00;
        end
    end

    // returned bits clear as the read data phase ends
    always_comb begin
        irq_clr = 8'h00;
        if (irq_dp_end) begin
            irq_clr = irq_snap;
        end
    end

    // sticky buffer, error and ready flags
    mfs_evt_flags #(
        .WIDTH(8),
        .IMPL(`MFS_IRQ_IMPL),
        .RESET(`MFS_IRQ_RESET)
    ) u_irq_flags (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .set_in(irq_set),
        .clr_in(irq_clr),
        .flags_out(irq_flags)
    );

    // step count capture
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            step_total <= `MFS_STEP_RESET;
        end else if (result_upd_in) begin
            step_total <= step_count_in;
        end
    end

    // gesture result capture, unknown until the first update
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gest_code <= MFS_GEST_UNKNOWN;
        end else if (result_upd_in) begin
            gest_code <= gesture_in;
        end
    end

    // activity result capture, unknown until the first update
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            act_code <= MFS_ACT_UNKNOWN;
        end else if (result_upd_in) begin
            act_code <= activity_in;
        end
    end

    // level interrupt from any unmasked pending flag
    assign next_irq = |(feat_flags & feat_mask) | |(irq_flags & irq_mask);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= next_irq;
        end
    end

    // size is accepted as word only; other sizes act as word access
    logic unused_size;
    assign unused_size = ^hsize_in;
endmodule

// file: rtl/mfs_cfg.svh
// Purpose: offsets, field positions, reset values and timing of the status bank
// Assumes: included by bare name from every design file that needs it
// Notes: register index times four gives the byte address
`ifndef MFS_CFG_SVH
`define MFS_CFG_SVH

// register indices, byte address is index * 4
`define MFS_IDX_FEAT 8'h1C
`define MFS_IDX_IRQ 8'h1D
`define MFS_IDX_STEP_LO 8'h1E
`define MFS_IDX_STEP_HI 8'h1F
`define MFS_IDX_GEST_ACT 8'h20
`define MFS_IDX_FEAT_MASK 8'h30
`define MFS_IDX_IRQ_MASK 8'h31
`define MFS_IDX_STEP_CFG 8'h32

// feature flag bit positions
`define MFS_FEAT_SIG_MOTION 0
`define MFS_FEAT_STEP 1
`define MFS_FEAT_ACTIVITY 2
`define MFS_FEAT_WEAR_WAKE 3
`define MFS_FEAT_GESTURE 4
`define MFS_FEAT_STILL 5
`define MFS_FEAT_MOTION 6

// buffer, error and data-ready flag bit positions
`define MFS_IRQ_BUF_FULL 0
`define MFS_IRQ_BUF_WM 1
`define MFS_IRQ_ERROR 2
`define MFS_IRQ_AUX_RDY 5
`define MFS_IRQ_GYR_RDY 6
`define MFS_IRQ_ACC_RDY 7

// result field positions
`define MFS_GEST_LSB 0
`define MFS_GEST_MSB 2
`define MFS_ACT_LSB 3
`define MFS_ACT_MSB 4

// reset values and implemented-bit masks
`define MFS_FEAT_RESET 8'h00
`define MFS_IRQ_RESET 8'h00
`define MFS_STEP_RESET 16'h0000
`define MFS_GEST_RESET 3'h0
`define MFS_ACT_RESET 2'h3
`define MFS_MASK_RESET 8'h00
`define MFS_FEAT_IMPL 8'h7F
`define MFS_IRQ_IMPL 8'hE7

// bus answer timing, wait states between address phase and data phase end; not read by the design, hreadyout_out is always 1
`define MFS_WAIT_STATES 0

`endif

// file: rtl/mfs_pkg.sv
// Purpose: types shared by the status bank files
// Assumes: nothing beyond the configuration header
// Notes: one-hot codes for the bus phase tracker
package mfs_pkg;

    typedef enum logic [2:0] {
        MFS_PH_IDLE = 3'b001,
        MFS_PH_RD = 3'b010,
        MFS_PH_WR = 3'b100
    } mfs_phase_e;

    typedef enum logic [2:0] {
        MFS_GEST_UNKNOWN = 3'h0,
        MFS_GEST_PUSH_DOWN = 3'h1,
        MFS_GEST_PIVOT_UP = 3'h2,
        MFS_GEST_SHAKE = 3'h3,
        MFS_GEST_FLICK_IN = 3'h4,
        MFS_GEST_FLICK_OUT = 3'h5
    } mfs_gest_e;

    typedef enum logic [1:0] {
        MFS_ACT_STILL = 2'h0,
        MFS_ACT_WALK = 2'h1,
        MFS_ACT_RUN = 2'h2,
        MFS_ACT_UNKNOWN = 2'h3
    } mfs_act_e;

    typedef logic [7:0] mfs_byte_t;

endpackage

// file: rtl/mfs_evt_flags.sv
// Purpose: bank of sticky event flags with selective clear
// Assumes: set and clear are one-cycle qualified masks
// Notes: set beats clear, unimplemented bits stay zero
`timescale 1ns/100ps
module mfs_evt_flags #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] IMPL = '1,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] flags_out
);
    genvar gi;

    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            if (IMPL[gi]) begin : g_impl
                always_ff @(posedge mclk_in or negedge rstn_in) begin
                    if (!rstn_in) begin
                        flags_out[gi] <= RESET[gi];
                    end else if (set_in[gi]) begin
                        flags_out[gi] <= 1'b1;
                    end else if (clr_in[gi]) begin
                        flags_out[gi] <= 1'b0;
                    end
                end
            end else begin : g_rsv
                assign flags_out[gi] = 1'b0;
            end
        end
    endgenerate
endmodule

// file: tb/mfs_status_bank_checker.sv
// Purpose: port-level checks of the status bank
// Assumes: bound to the status bank top, zero wait states
// Notes: reads are decoded from the address phase
`timescale 1ns/100ps
module mfs_status_bank_checker (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic sig_motion_in,
    input wire logic step_wm_in,
    input wire logic step_det_in,
    input wire logic activity_chg_in,
    input wire logic wear_wake_in,
    input wire logic gesture_det_in,
    input wire logic still_det_in,
    input wire logic motion_det_in,
    input wire logic buf_full_in,
    input wire logic buf_wm_in,
    input wire logic error_in,
    input wire logic aux_rdy_in,
    input wire logic gyr_rdy_in,
    input wire logic acc_rdy_in,
    input wire logic [15:0] step_count_in,
    input wire logic result_upd_in,
    input wire mfs_pkg::mfs_gest_e gesture_in,
    input wire mfs_pkg::mfs_act_e activity_in
);
    import mfs_pkg::*;
    logic take, r70, r74, feat_ev, irq_ev;
    assign take = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
    assign r70 = take && haddr_in == 32'h70;
    assign r74 = take && haddr_in == 32'h74;
    assign feat_ev = |{sig_motion_in, step_wm_in, step_det_in, activity_chg_in, wear_wake_in,
        gesture_det_in, still_det_in, motion_det_in};
    assign irq_ev = |{buf_full_in, buf_wm_in, error_in, aux_rdy_in, gyr_rdy_in, acc_rdy_in};
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    property p_feat_clr;
        (r70 && !feat_ev) ##1 !feat_ev ##1 r70 |=> hrdata_out[7:0] == 8'h00;
    endproperty
    a_feat_clr: assert property (p_feat_clr) else $error("feature flags kept");
    property p_irq_clr;
        (r74 && !irq_ev) ##1 !irq_ev ##1 r74 |=> hrdata_out[7:0] == 8'h00;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq flags kept");
    property p_feat_rsv;
        r70 |=> hrdata_out[31:7] == 25'h0;
    endproperty
    a_feat_rsv: assert property (p_feat_rsv) else $error("reserved bits set");
    property p_gest_bit;
        gesture_det_in ##1 r70 |=> hrdata_out[4];
    endproperty
    a_gest_bit: assert property (p_gest_bit) else $error("gesture flag missing");
    property p_full_bit;
        buf_full_in ##1 r74 |=> hrdata_out[0];
    endproperty
    a_full_bit: assert property (p_full_bit) else $error("buffer full flag missing");
    property p_acc_bit;
        acc_rdy_in ##1 r74 |=> hrdata_out[7] && hrdata_out[4:3] == 2'h0;
    endproperty
    a_acc_bit: assert property (p_acc_bit) else $error("acceleration flag wrong");
    property p_step;
        result_upd_in ##1 (take && (haddr_in == 32'h78 || haddr_in == 32'h7C)) |=>
            hrdata_out[7:0] == ($past(haddr_in[2]) ? $past(step_count_in[15:8], 2) :
            $past(step_count_in[7:0], 2));
    endproperty
    a_step: assert property (p_step) else $error("step count byte wrong");
    property p_result;
        result_upd_in ##1 (take && haddr_in == 32'h80) |=>
            hrdata_out[7:0] == {3'h0, $past(activity_in, 2), $past(gesture_in, 2)};
    endproperty
    a_result: assert property (p_result) else $error("result codes wrong");
    property p_late;
        r74 ##1 acc_rdy_in ##1 r74 |=> hrdata_out[7];
    endproperty
    a_late: assert property (p_late) else $error("late event lost");
endmodule

// file: tb/mfs_host_model.sv
// Purpose: host side bus master reading the status bank
// Assumes: tasks are entered right after a rising clock edge
// Notes: single word transfers, waits on hready
`timescale 1ns/100ps
module mfs_host_model (
    input wire logic mclk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    initial begin
        hsel_out = 1'b1;
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        htrans_out <= 2'h2;
        haddr_out <= addr;
        hwrite_out <= wr;
        do @(posedge mclk_in); while (hready_in !== 1'b1);
        htrans_out <= 2'h0;
        hwdata_out <= wdata;
        do @(posedge mclk_in); while (hready_in !== 1'b1);
        rdata = hrdata_in;
    endtask
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench for the motion feature status bank
// Assumes: zero wait state bus, one host master
// Notes: event inputs are pulsed for one cycle each
`timescale 1ns/100ps
module tb_top;
    import mfs_pkg::*;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out, irq_out;
    logic result_upd_in = 1'b0;
    logic [1:0] htrans_in;
    logic [2:0] hsize_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rdat;
    logic [15:0] step_count_in = 16'h0000;
    mfs_gest_e gesture_in = MFS_GEST_UNKNOWN;
    mfs_act_e activity_in = MFS_ACT_STILL;
    logic [13:0] ev = 14'h0000;
    logic sig_motion_in, step_wm_in, step_det_in, activity_chg_in, wear_wake_in, gesture_det_in;
    logic still_det_in, motion_det_in, buf_full_in, buf_wm_in, error_in, aux_rdy_in;
    logic gyr_rdy_in, acc_rdy_in;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    assign {acc_rdy_in, gyr_rdy_in, aux_rdy_in, error_in, buf_wm_in, buf_full_in, motion_det_in,
        still_det_in, gesture_det_in, wear_wake_in, activity_chg_in, step_det_in, step_wm_in,
        sig_motion_in} = ev;
    assign hready_in = hreadyout_out;
    mfs_status_bank i_dut (.*);
    mfs_host_model i_host (.mclk_in(mclk_in), .hready_in(hready_in), .hrdata_in(hrdata_out),
        .hsel_out(hsel_in), .haddr_out(haddr_in), .htrans_out(htrans_in),
        .hwrite_out(hwrite_in), .hsize_out(hsize_in), .hwdata_out(hwdata_in));
    always #2.5 mclk_in = ~mclk_in;
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        i_host.xfer(1'b0, a, 32'h0, rdat);
        chk(what, exp, rdat);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, rdat);
    endtask
    task automatic pulse(input int i);
        ev <= 14'h0001 << i;
        @(posedge mclk_in);
        ev <= 14'h0000;
    endtask
    task automatic upd();
        result_upd_in <= 1'b1;
        @(posedge mclk_in);
        result_upd_in <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        rd(32'h70, 32'h0, "feature reset");
        rd(32'h74, 32'h0, "irq reset");
        rd(32'h78, 32'h0, "step low reset");
        rd(32'h7C, 32'h0, "step high reset");
        rd(32'h80, 32'h18, "result reset");
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            rd(32'h70, (i == 2) ? 32'h0 : 32'h1 << ((i < 2) ? i : i - 1), "feature");
            rd(32'h70, 32'h0, "feature cleared");
        end
        wr(32'hC8, 32'h1);
        pulse(2);
        rd(32'h70, 32'h2, "step detector");
        pulse(1);
        rd(32'h70, 32'h0, "step watermark off");
        wr(32'h70, 32'hFF);
        rd(32'h70, 32'h0, "read-only feature");
        rd(32'h100, 32'h0, "unmapped");
        chk("bus response", 32'h0, {31'h0, hresp_out});
        wr(32'hC0, 32'hFF);
        rd(32'hC0, 32'h7F, "feature mask");
        $display("test feature flags done");
        for (int i = 8; i < 14; i++) begin
            pulse(i);
            rd(32'h74, 32'h1 << ((i < 11) ? i - 8 : i - 6), "irq flag");
            rd(32'h74, 32'h0, "irq cleared");
        end
        pulse(13);
        fork
            rd(32'h74, 32'h80, "irq before late event");
            begin
                @(posedge mclk_in);
                ev <= 14'h2000;
                @(posedge mclk_in);
                ev <= 14'h0000;
            end
        join
        rd(32'h74, 32'h80, "late event kept");
        rd(32'h74, 32'h0, "late event cleared");
        $display("test irq flags done");
        for (int i = 0; i < 6; i++) begin
            gesture_in <= mfs_gest_e'(i);
            activity_in <= mfs_act_e'(i % 4);
            step_count_in <= 16'hA55A ^ 16'(i * 257);
            upd();
            rd(32'h80, 32'((i % 4) * 8 + i), "result codes");
            upd();
            rd(32'h78, 32'(8'h5A ^ 8'(i)), "step low");
            upd();
            rd(32'h7C, 32'(8'hA5 ^ 8'(i)), "step high");
        end
        $display("test results done");
        wr(32'hC4, 32'h80);
        rd(32'hC4, 32'h80, "irq mask");
        pulse(12);
        repeat (2) @(posedge mclk_in);
        #1 chk("irq masked", 32'h0, {31'h0, irq_out});
        @(posedge mclk_in);
        pulse(13);
        repeat (2) @(posedge mclk_in);
        #1 chk("irq raised", 32'h1, {31'h0, irq_out});
        @(posedge mclk_in);
        rd(32'h74, 32'hC0, "irq flags");
        repeat (2) @(posedge mclk_in);
        #1 chk("irq cleared", 32'h0, {31'h0, irq_out});
        @(posedge mclk_in);
        pulse(0);
        repeat (2) @(posedge mclk_in);
        #1 chk("feature irq", 32'h1, {31'h0, irq_out});
        @(posedge mclk_in);
        rd(32'h70, 32'h1, "feature irq flag");
        $display("test interrupt done");
        report_and_stop();
    end
endmodule
bind mfs_status_bank mfs_status_bank_checker i_chk (.*);
